/* File: hdl/stg_pkg.sv */
package stg_pkg;

  // Clock and line rate
  localparam int CLK_HZ             = 125_000_000;
  localparam int BAUD_DEFAULT       = 9600;
  localparam int BAUD_MIN           = 300;
  // Whole cycles per bit, rounded down so the rate never falls below the figure
  localparam int BIT_CYCLES_DEFAULT = CLK_HZ / BAUD_DEFAULT;
  localparam int BIT_CYCLES_MAX     = CLK_HZ / BAUD_MIN;
  localparam int BAUD_CNT_W         = 20;

  // Frame layout: start, 8 payload bits, stop
  localparam logic [3:0] FRAME_BITS = 4'h9;

  // Character codes
  localparam logic [7:0] CH_SOH   = 8'h01;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_QMARK = 8'h3f;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;

  // Character positions
  localparam logic [3:0] QUAL_IDX     = 4'hd;
  localparam logic [3:0] LAST_IDX_DOY = 4'hf;
  localparam logic [3:0] LAST_IDX_PAR = 4'he;

  // Blanking: 2 min 30 s out of every 5 min
  localparam logic [5:0] BLANK_PERIOD_MIN = 6'h05;
  localparam logic [8:0] SEC_PER_MIN      = 9'h03c;
  localparam logic [8:0] BLANK_LEN_SEC    = 9'h096;

  // Reset values
  localparam logic       RESET_LINE = 1'b1;

  typedef enum logic [1:0] {
    MODE_CONT   = 2'b00,
    MODE_BLANK  = 2'b01,
    MODE_PARITY = 2'b10,
    MODE_SPARE  = 2'b11
  } stg_mode_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } stg_state_t;

endpackage : stg_pkg

/* File: hdl/stg_char_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Character stream from framer to serialiser
interface stg_char_if;
  logic       valid;
  logic       ready;
  logic       idle;
  logic [7:0] data;
  logic       parity7;

  modport src (output valid, output data, output parity7, input ready, input idle);
  modport snk (input valid, input data, input parity7, output ready, output idle);
endinterface : stg_char_if

`default_nettype wire

/* File: hdl/stg_uart_tx.sv */
`timescale 1ns/1ps
`default_nettype none

module stg_uart_tx #(
  parameter int BitCycles = stg_pkg::BIT_CYCLES_DEFAULT
) (
  input  wire logic clk,
  input  wire logic rst,
  stg_char_if.snk   chr,
  output logic      txd
);

  logic [8:0]                     mem_q [2];
  logic                           wrPtr_q;
  logic                           rdPtr_q;
  logic [1:0]                     count_q;
  logic [9:0]                     shift_q;
  logic [3:0]                     bitsLeft_q;
  logic [stg_pkg::BAUD_CNT_W-1:0] baud_q;
  logic                           busy_q;
  logic                           txd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer: a stall on the line pushes back on the framer
  wire       push     = chr.valid && chr.ready;
  wire       pop      = !busy_q && (count_q != 2'h0);
  wire [8:0] head     = mem_q[rdPtr_q];
  wire [6:0] low7     = head[6:0];
  wire       headPar  = head[8];
  // Odd parity over seven bits, else the eighth data bit
  wire       payload7 = headPar ? ~^low7 : head[7];
  wire [9:0] frame    = {1'b1, payload7, low7, 1'b0};
  wire       bitDone  = (baud_q == '0);

  assign chr.ready = (count_q != 2'h2);
  assign chr.idle  = !busy_q && (count_q == 2'h0);
  assign txd       = txd_q;

  // Buffer pointers and storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q  <= 1'b0;
      rdPtr_q  <= 1'b0;
      count_q  <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      if (push) begin
        mem_q[wrPtr_q] <= {chr.parity7, chr.data};
        wrPtr_q        <= !wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= !rdPtr_q;
      end
      count_q <= 2'(count_q + {1'b0, push} - {1'b0, pop});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit engine: start bit leaves on the pop, LSB first, stop bit last
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txd_q      <= stg_pkg::RESET_LINE;
      shift_q    <= '1;
      bitsLeft_q <= 4'h0;
      baud_q     <= '0;
      busy_q     <= 1'b0;
    end else if (pop) begin
      txd_q      <= frame[0];
      shift_q    <= {1'b1, frame[9:1]};
      bitsLeft_q <= stg_pkg::FRAME_BITS;
      baud_q     <= stg_pkg::BAUD_CNT_W'(BitCycles - 1);
      busy_q     <= 1'b1;
    end else if (busy_q) begin
      if (!bitDone) begin
        baud_q <= stg_pkg::BAUD_CNT_W'(baud_q - 1'b1);
      end else if (bitsLeft_q != 4'h0) begin
        txd_q      <= shift_q[0];
        shift_q    <= {1'b1, shift_q[9:1]};
        bitsLeft_q <= 4'(bitsLeft_q - 4'h1);
        baud_q     <= stg_pkg::BAUD_CNT_W'(BitCycles - 1);
      end else begin
        busy_q <= 1'b0;
        txd_q  <= stg_pkg::RESET_LINE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_IDLE_MARK: assert property (!busy_q |-> txd_q)
    else $error("line not at mark while idle");
  AST_FRAME_PARITY: assert property (pop && headPar |-> (^frame[8:1]) && frame[9] && !frame[0])
    else $error("odd parity frame malformed");
  AST_START_BIT: assert property (pop |=> !txd_q ##1 (!txd_q || BitCycles == 1))
    else $error("start bit not driven after pop");

endmodule : stg_uart_tx

`default_nettype wire

/* File: hdl/stg_time_string_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - SOH start bit leaves a few cycles after the second tick, well inside one bit.
// - Day-of-year string is 16 characters: SOH ddd:hh:mm:ss quality CR LF.
// - Day of year sent as three ASCII digits, 001 to 366.
// - Hours as two digits 00-23, minutes as two digits 00-59.
// - Seconds as two digits 00-59, and 60 passed through in a leap second.
// - Quality character is space when synchronized, question mark otherwise.
// - Day-of-year strings end with CR 0Dh then LF 0Ah.
// - Blanked mode suppresses strings for 2 min 30 s every 5 min.
// - Parity mode frames each character as start, 7 data, odd parity, stop.
// - Parity mode: start bit leading edge marks the second; receiver treats it so.
// - Parity mode sends 15 characters once per second at 300 baud or more.
// - Parity mode string: SOH, day:hh:mm:ss, CR, LF; time is the start-bit second.
// - Parity mode day is the ordinal day, 1 to 366.
// - Every day-of-year string opens with SOH, byte 01h.

module stg_time_string_gen #(
  parameter int BitCycles = stg_pkg::BIT_CYCLES_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       secTick,
  input  wire logic       syncOkPin,
  input  wire logic [1:0] modePin,
  input  wire logic [8:0] dayOfYear,
  input  wire logic [4:0] hours,
  input  wire logic [5:0] minutes,
  input  wire logic [5:0] seconds,
  output logic            txd,
  output logic            sending
);

  stg_char_if chr ();

  logic               syncMeta_q;
  logic               syncOk_q;
  logic [1:0]         modeMeta_q;
  logic [1:0]         mode_q;
  logic [8:0]         day_q;
  logic [4:0]         hour_q;
  logic [5:0]         min_q;
  logic [5:0]         sec_q;
  logic               synced_q;
  logic               parity_q;
  logic [3:0]         idx_q;
  logic [7:0]         data_q;
  stg_pkg::stg_state_t state_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pins from outside the clock domain pass two flops first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncMeta_q <= 1'b0;
      syncOk_q   <= 1'b0;
      modeMeta_q <= stg_pkg::MODE_CONT;
      mode_q     <= stg_pkg::MODE_CONT;
    end else begin
      syncMeta_q <= syncOkPin;
      syncOk_q   <= syncMeta_q;
      modeMeta_q <= modePin;
      mode_q     <= modeMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blanking window from the new second's position in its 5-minute slot
  wire [8:0] minMod      = {3'h0, minutes % stg_pkg::BLANK_PERIOD_MIN};
  wire [8:0] secInPeriod = 9'(minMod * stg_pkg::SEC_PER_MIN) + {3'h0, seconds};
  wire       blankNow    = (secInPeriod < stg_pkg::BLANK_LEN_SEC);
  wire       blankMode   = (mode_q == stg_pkg::MODE_BLANK);
  wire       parityMode  = (mode_q == stg_pkg::MODE_PARITY);

  // A string still on the line drops the tick rather than start late
  wire fire   = secTick && (state_q == stg_pkg::ST_IDLE) && chr.idle
                && !(blankMode && blankNow);
  wire accept = chr.valid && chr.ready;
  wire [3:0] lastIdx = parity_q ? stg_pkg::LAST_IDX_PAR : stg_pkg::LAST_IDX_DOY;

  ////////////////////////////////////////////////////////////////////////////
  // Decimal digits of the latched time
  wire [3:0] dayH  = 4'(day_q / 9'd100);
  wire [3:0] dayT  = 4'((day_q / 9'd10) % 9'd10);
  wire [3:0] dayO  = 4'(day_q % 9'd10);
  wire [3:0] hourT = 4'(hour_q / 5'd10);
  wire [3:0] hourO = 4'(hour_q % 5'd10);
  wire [3:0] minT  = 4'(min_q / 6'd10);
  wire [3:0] minO  = 4'(min_q % 6'd10);
  wire [3:0] secT  = 4'(sec_q / 6'd10);
  wire [3:0] secO  = 4'(sec_q % 6'd10);

  function automatic logic [7:0] dig(input logic [3:0] d);
    return stg_pkg::CH_ZERO + {4'h0, d};
  endfunction : dig

  // Parity strings drop the quality slot, so positions past it shift by one
  wire [3:0] nextIdx = 4'(idx_q + 4'h1);
  wire [3:0] slot    = (parity_q && nextIdx >= stg_pkg::QUAL_IDX) ?
                       4'(nextIdx + 4'h1) : nextIdx;
  wire [7:0] qualCh  = synced_q ? stg_pkg::CH_SPACE : stg_pkg::CH_QMARK;
  logic [7:0] nextChar;

  // Character at each slot of the string
  always_comb begin
    unique case (slot)
      4'h0:               nextChar = stg_pkg::CH_SOH;
      4'h1:               nextChar = dig(dayH);
      4'h2:               nextChar = dig(dayT);
      4'h3:               nextChar = dig(dayO);
      4'h4, 4'h7, 4'ha:   nextChar = stg_pkg::CH_COLON;
      4'h5:               nextChar = dig(hourT);
      4'h6:               nextChar = dig(hourO);
      4'h8:               nextChar = dig(minT);
      4'h9:               nextChar = dig(minO);
      4'hb:               nextChar = dig(secT);
      4'hc:               nextChar = dig(secO);
      4'hd:               nextChar = qualCh;
      4'he:               nextChar = stg_pkg::CH_CR;
      4'hf:               nextChar = stg_pkg::CH_LF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: time is captured at the tick, so fields name the start-bit second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q  <= stg_pkg::ST_IDLE;
      idx_q    <= 4'h0;
      data_q   <= stg_pkg::CH_SOH;
      day_q    <= '0;
      hour_q   <= '0;
      min_q    <= '0;
      sec_q    <= '0;
      synced_q <= 1'b0;
      parity_q <= 1'b0;
    end else if (fire) begin
      state_q  <= stg_pkg::ST_SEND;
      idx_q    <= 4'h0;
      data_q   <= stg_pkg::CH_SOH;
      day_q    <= dayOfYear;
      hour_q   <= hours;
      min_q    <= minutes;
      sec_q    <= seconds;
      synced_q <= syncOk_q;
      parity_q <= parityMode;
    end else if (accept) begin
      if (idx_q == lastIdx) begin
        state_q <= stg_pkg::ST_IDLE;
      end else begin
        idx_q  <= nextIdx;
        data_q <= nextChar;
      end
    end
  end

  assign chr.valid   = (state_q == stg_pkg::ST_SEND);
  assign chr.data    = data_q;
  assign chr.parity7 = parity_q;
  assign sending     = chr.valid;

  // Serialiser with its two-entry buffer
  stg_uart_tx #(
    .BitCycles (BitCycles)
  ) u_tx (
    .clk (clk),
    .rst (rst),
    .chr (chr),
    .txd (txd)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wire isColonPos = (idx_q == 4'h4) || (idx_q == 4'h7) || (idx_q == 4'ha);
  wire isDigitPos = (idx_q != 4'h0) && !isColonPos && (idx_q < stg_pkg::QUAL_IDX);

  sequence sTickGo;
    fire;
  endsequence
  sequence sLastChar;
    accept && (idx_q == lastIdx);
  endsequence

  AST_SOH_FIRST: assert property (sTickGo |=> chr.valid && chr.data == stg_pkg::CH_SOH)
    else $error("string did not open with SOH");
  AST_ON_TIME: assert property (sTickGo |-> ##[1:4] !txd)
    else $error("start bit late after second tick");
  AST_CR_LF: assert property (accept && chr.data == stg_pkg::CH_CR
                              |=> chr.valid && chr.data == stg_pkg::CH_LF)
    else $error("CR not followed by LF");
  AST_QUALITY: assert property (accept && idx_q == stg_pkg::QUAL_IDX && !parity_q
                                |-> chr.data == (synced_q ? stg_pkg::CH_SPACE
                                                          : stg_pkg::CH_QMARK))
    else $error("quality character wrong");
  AST_BLANKED: assert property (secTick && blankMode && blankNow
                                && state_q == stg_pkg::ST_IDLE
                                |=> state_q == stg_pkg::ST_IDLE [*2])
    else $error("string sent inside blanking");
  AST_SEPARATOR: assert property (accept && isColonPos |-> chr.data == stg_pkg::CH_COLON)
    else $error("separator not a colon");
  AST_DIGITS: assert property (accept && isDigitPos && !(parity_q && idx_q >= 4'hd)
                               |-> chr.data >= stg_pkg::CH_ZERO
                                   && chr.data <= stg_pkg::CH_NINE)
    else $error("time field not a digit");
  AST_END: assert property (sLastChar |-> chr.data == stg_pkg::CH_LF ##1 !chr.valid)
    else $error("string did not end on LF");
  // Without the quality slot, CR must follow the last seconds digit directly
  AST_PARITY_LEN: assert property (accept && parity_q && idx_q == stg_pkg::QUAL_IDX
                                   |-> chr.data == stg_pkg::CH_CR)
    else $error("parity string length wrong");

endmodule : stg_time_string_gen

`default_nettype wire

/* File: dv/stg_line_rx.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural receiver at the far end of the serial line
module stg_line_rx #(
  parameter int BitCycles = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic txd,
  input wire logic parMode
);
  logic [7:0] got[$];
  int         bad;
  logic [7:0] bits;

  //////////////////////////////////////////////////////////////////////////////
  // Hunt for a start bit, then sample each bit mid-cell so edge jitter is harmless
  initial begin
    bad = 0;
    forever begin
      @(posedge clk);
      if (rst !== 1'b1 && txd === 1'b0) begin
        repeat (BitCycles / 2) @(posedge clk);
        if (txd !== 1'b0) bad++;
        for (int i = 0; i < 8; i++) begin
          repeat (BitCycles) @(posedge clk);
          bits[i] = txd;
        end
        repeat (BitCycles) @(posedge clk);
        if (txd !== 1'b1) bad++;
        if (parMode === 1'b1) begin
          if (^bits !== 1'b1) bad++;
          got.push_back({1'b0, bits[6:0]});
        end else begin
          got.push_back(bits);
        end
      end
    end
  end
endmodule : stg_line_rx

`default_nettype wire

/* File: dv/serial_time_string_generator_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_time_string_generator_tb;
  localparam int BC      = 8;
  localparam int TIMEOUT = 40000;

  logic       clk;
  logic       rst;
  logic       secTick;
  logic       syncOkPin;
  logic [1:0] modePin;
  logic [8:0] dayOfYear;
  logic [4:0] hours;
  logic [5:0] minutes;
  logic [5:0] seconds;
  wire logic  txd;
  wire logic  sending;
  wire logic  parMode;
  logic [7:0] expQ[$];
  int         numErrors;
  int         nTests;
  int         cycles = 0;

  assign parMode = (modePin == 2'b10);

  //////////////////////////////////////////////////////////////////////////////
  // Small bit time keeps a whole string near 1300 cycles
  stg_time_string_gen #(.BitCycles(BC)) uut (
    .clk(clk), .rst(rst), .secTick(secTick), .syncOkPin(syncOkPin), .modePin(modePin),
    .dayOfYear(dayOfYear), .hours(hours), .minutes(minutes), .seconds(seconds),
    .txd(txd), .sending(sending)
  );

  stg_line_rx #(.BitCycles(BC)) rx (
    .clk(clk), .rst(rst), .txd(txd), .parMode(parMode)
  );

  always #4 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      numErrors++;
      $display("unexpected run length: expected below %0d, seen %0d", TIMEOUT, cycles);
      tallyAndFinish();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
    end
  endtask : chk8

  task automatic chkn(input string name, input int exp, input int got);
    nTests++;
    if (got != exp) begin
      numErrors++;
      $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
    end
  endtask : chkn

  function automatic logic [7:0] dig(input int v);
    return stg_pkg::CH_ZERO + 8'(v % 10);
  endfunction : dig

  // Expected string worked out from the field values
  task automatic mkExp(input bit par, input bit syn, input int d, h, m, s);
    expQ = {stg_pkg::CH_SOH, dig(d / 100), dig(d / 10), dig(d), stg_pkg::CH_COLON,
            dig(h / 10), dig(h), stg_pkg::CH_COLON, dig(m / 10), dig(m),
            stg_pkg::CH_COLON, dig(s / 10), dig(s)};
    if (!par) expQ.push_back(syn ? stg_pkg::CH_SPACE : stg_pkg::CH_QMARK);
    expQ.push_back(stg_pkg::CH_CR);
    expQ.push_back(stg_pkg::CH_LF);
  endtask : mkExp

  // Pins pass a two-flop synchroniser, so give them a few edges
  task automatic setPins(input logic [1:0] md, input logic syn);
    @(posedge clk);
    #1;
    modePin = md;
    syncOkPin = syn;
    repeat (4) @(posedge clk);
  endtask : setPins

  task automatic fire(input int d, h, m, s);
    @(posedge clk);
    #1;
    dayOfYear = 9'(d);
    hours = 5'(h);
    minutes = 6'(m);
    seconds = 6'(s);
    secTick = 1'b1;
    @(posedge clk);
    #1;
    secTick = 1'b0;
  endtask : fire

  task automatic latency();
    int n;
    n = 0;
    chk8("sending after tick", 8'h01, {7'h00, sending});
    // Tick edge, push edge, pop edge: the start bit shows two edges after we look
    while (txd !== 1'b0 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chkn("start bit delay", 2, n);
  endtask : latency

  // A dropped string must leave the line at mark and the framer idle
  task automatic quiet();
    int lows;
    lows = 0;
    repeat (160 * BC) begin
      @(posedge clk);
      #1;
      if (txd !== 1'b1 || sending !== 1'b0) lows++;
    end
    chkn("blanked line activity", 0, lows);
  endtask : quiet

  // One character may be on the line and two more in the buffer when sending drops
  task automatic drain();
    int n;
    n = 0;
    while (sending !== 1'b0 && n < 200 * BC) begin
      @(posedge clk);
      n++;
    end
    repeat (30 * BC + 8) @(posedge clk);
  endtask : drain

  task automatic checkStr();
    chkn("char count", expQ.size(), rx.got.size());
    foreach (expQ[i]) begin
      if (i < rx.got.size()) chk8("char", expQ[i], rx.got[i]);
    end
    chkn("bad frames", 0, rx.bad);
  endtask : checkStr

  task automatic runStr(input logic [1:0] md, input bit syn, input int d, h, m, s,
                        input bit out);
    setPins(md, syn);
    rx.got.delete();
    expQ.delete();
    if (out) mkExp(md == 2'b10, syn, d, h, m, s);
    fire(d, h, m, s);
    if (out) latency();
    else quiet();
    drain();
    checkStr();
  endtask : runStr

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic scnLeap();
    runStr(2'b00, 1'b1, 366, 23, 59, 60, 1'b1);
  endtask : scnLeap

  task automatic scnUnsync();
    runStr(2'b00, 1'b0, 1, 0, 0, 0, 1'b1);
    runStr(2'b11, 1'b1, 7, 9, 8, 5, 1'b1);
  endtask : scnUnsync

  task automatic scnParity();
    runStr(2'b10, 1'b1, 45, 12, 34, 56, 1'b1);
    runStr(2'b10, 1'b0, 300, 0, 7, 0, 1'b1);
  endtask : scnParity

  // Window edges: first 150 s of each five-minute slot are silent
  task automatic scnBlank();
    runStr(2'b01, 1'b1, 100, 3, 0, 0, 1'b0);
    runStr(2'b01, 1'b1, 100, 3, 2, 29, 1'b0);
    runStr(2'b01, 1'b1, 100, 3, 2, 30, 1'b1);
    runStr(2'b01, 1'b1, 100, 3, 4, 59, 1'b1);
    runStr(2'b01, 1'b1, 100, 3, 5, 0, 1'b0);
  endtask : scnBlank

  // A tick landing mid-string is dropped; the running string stays whole
  task automatic scnRefuse();
    setPins(2'b00, 1'b1);
    rx.got.delete();
    mkExp(1'b0, 1'b1, 100, 10, 20, 30);
    fire(100, 10, 20, 30);
    latency();
    repeat (40) @(posedge clk);
    fire(200, 1, 2, 3);
    drain();
    checkStr();
  endtask : scnRefuse

  task automatic tallyAndFinish();
    $display("checks %0d, mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tallyAndFinish

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    secTick = 1'b0;
    syncOkPin = 1'b0;
    modePin = 2'b00;
    dayOfYear = 9'h001;
    hours = 5'h00;
    minutes = 6'h00;
    seconds = 6'h00;
    numErrors = 0;
    nTests = 0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    chk8("idle line", 8'h01, {7'h00, txd});
    scnLeap();
    scnUnsync();
    scnParity();
    scnBlank();
    scnRefuse();
    tallyAndFinish();
  end
endmodule : serial_time_string_generator_tb

`default_nettype wire
